// ### inc/freq_ramp_pkg.sv
/*
  Shared constants and types of the frequency reference and ramp block.
  Assumes a 10 MHz pclk and frequencies held in 0.01 Hz units.
*/
package freq_ramp_pkg;

  typedef logic [15:0] freq_t;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] CTRL_ADDR      = 8'h00;
  localparam logic [7:0] AUX_PCT_ADDR   = 8'h04;
  localparam logic [7:0] OFFSET_ADDR    = 8'h08;
  localparam logic [7:0] PRESET_ADDR    = 8'h0C;
  localparam logic [7:0] MAXF_ADDR      = 8'h10;
  localparam logic [7:0] UPPER_ADDR     = 8'h14;
  localparam logic [7:0] UL_OFFSET_ADDR = 8'h18;
  localparam logic [7:0] LOWER_ADDR     = 8'h1C;
  localparam logic [7:0] COMM_UL_ADDR   = 8'h20;
  localparam logic [7:0] COMM_SRC_ADDR  = 8'h24;
  localparam logic [7:0] OUTF_ADDR      = 8'h28;
  localparam logic [7:0] SETF_ADDR      = 8'h2C;
  localparam logic [7:0] UL_FINAL_ADDR  = 8'h30;
  localparam logic [7:0] STATUS_ADDR    = 8'h34;
  localparam logic [7:0] TIME_BASE_ADDR = 8'h40;
  localparam logic [7:0] TIME_LAST_ADDR = 8'h5C;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int COMBO_LSB = 0;
  localparam int REL_LSB   = 4;
  localparam int AUX_REF   = 6;
  localparam int TRIM_BASE = 7;
  localparam int TRIM_MEM  = 8;
  localparam int ULSRC_LSB = 9;
  localparam int BELOW_LSB = 12;
  localparam int UNIT_LSB  = 14;
  localparam int REFSEL_LSB = 16;
  localparam int ASRC_LSB  = 18;
  localparam int BSRC_LSB  = 21;
  localparam int RUN_BIT   = 24;
  localparam int RES_LSB   = 28;
  localparam logic [31:0] CTRL_RST = 32'h0000_4000;
  localparam logic [1:0]  RESOLUTION_CODE = 2'h2;

  // ****************************************
  // Values in 0.01 Hz and percent units
  // ****************************************
  localparam freq_t FREQ_CAP     = 16'hEA60;
  localparam freq_t MAXF_MIN     = 16'h1388;
  localparam freq_t MAXF_RST     = 16'h1388;
  localparam freq_t PRESET_RST   = 16'h1388;
  localparam freq_t UPPER_RST    = 16'h1388;
  localparam freq_t REF_100HZ    = 16'h2710;
  localparam logic [15:0] PCT_FULL = 16'h2710;
  localparam logic [7:0]  AUX_PCT_RST = 8'h64;
  localparam logic [7:0]  AUX_PCT_MAX = 8'h96;
  localparam logic [15:0] AUX_PCT_DIV = 16'h0064;
  localparam freq_t TRIM_STEP    = 16'h0001;

  // ****************************************
  // Ramp time unit
  // ****************************************
  localparam int CLK_HZ          = 10_000_000;
  localparam int CENTI_UNIT_MS   = 10;
  localparam int CENTI_CYCLES    = CENTI_UNIT_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {UNIT_1S, UNIT_100MS, UNIT_10MS} time_unit_t;
  typedef enum logic [2:0] {SRC_DIGITAL, SRC_AN1, SRC_AN2, SRC_PULSE, SRC_COMM} src_t;

  typedef struct packed {
    freq_t       target;
    freq_t       reference;
    logic [39:0] accel_cycles;
    logic [39:0] decel_cycles;
  } ramp_req_t;

endpackage

// ### design/ramp_stepper.sv
/*
  Ramp generator: walks the output frequency toward a target.
  Assumes target and timing inputs come from logic on pclk.
*/
`timescale 1ns/100ps
module ramp_stepper
  import freq_ramp_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire freq_ramp_pkg::ramp_req_t req,
  output freq_ramp_pkg::freq_t        freq_q
);
  import freq_ramp_pkg::*;

  logic [39:0] acc_q;
  logic        up_q;
  logic        up;
  logic [39:0] span;
  logic [39:0] acc_next;

  assign up       = req.target > freq_q;
  assign span     = up ? req.accel_cycles : req.decel_cycles;
  assign acc_next = acc_q + {24'h00_0000, req.reference};

  // ****************************************
  // One 0.01 Hz step per threshold crossing
  // ****************************************
  // Nonzero span is never below 100000 cycles at the default CENTISECOND_CYCLES, so one step a cycle is enough
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freq_q <= 16'h0000;
      acc_q  <= 40'h00_0000_0000;
      up_q   <= 1'b0;
    end
    else if (req.target == freq_q)
    begin
      acc_q <= 40'h00_0000_0000;
    end
    else if (span == 40'h00_0000_0000 || req.reference == 16'h0000)
    begin
      freq_q <= req.target;
      acc_q  <= 40'h00_0000_0000;
    end
    else if (up != up_q)
    begin
      up_q  <= up;
      acc_q <= 40'h00_0000_0000;
    end
    else if (acc_next >= span)
    begin
      acc_q  <= acc_next - span;
      freq_q <= up ? freq_q + TRIM_STEP : freq_q - TRIM_STEP;
    end
    else
    begin
      acc_q <= acc_next;
    end
  end

endmodule // ramp_stepper

// ### design/freq_reference_ramp.sv
/*
  Frequency reference path with limits, trimming and ramp, behind APB.
  Assumes analog and pulse inputs arrive as 0.01 % words from
  asynchronous logic, and keys and terminals are raw pins.
*/
`timescale 1ns/100ps
module freq_reference_ramp
  import freq_ramp_pkg::*;
#(
  parameter int CENTISECOND_CYCLES = freq_ramp_pkg::CENTI_CYCLES
)
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [7:0]            paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [15:0]           analog_input_one,
  input  wire logic [15:0]           analog_input_two,
  input  wire logic [15:0]           pulse_input,
  input  wire logic [1:0]            digital_input_terminal,
  input  wire logic                  source_switch,
  input  wire logic                  up_trim,
  input  wire logic                  down_trim,
  output freq_ramp_pkg::freq_t       output_frequency,
  output logic                       run_active
);
  import freq_ramp_pkg::*;

  localparam int SW = 53;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic freq_t scale(input freq_t base, input logic [15:0] pct);
    logic [31:0] p;
    p = 32'(base) * 32'(pct) / 32'(PCT_FULL);
    return (p > 32'(FREQ_CAP)) ? FREQ_CAP : p[15:0];
  endfunction

  function automatic freq_t fmin(input freq_t a, input freq_t b);
    return (a < b) ? a : b;
  endfunction

  function automatic freq_t fmax(input freq_t a, input freq_t b);
    return (a > b) ? a : b;
  endfunction

  function automatic freq_t sat_add(input freq_t a, input freq_t b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[16] ? 16'hFFFF : s[15:0];
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [1:0]    trim_prev_q;
  logic [15:0]   an1;
  logic [15:0]   an2;
  logic [15:0]   pul;
  logic [1:0]    group_sel;
  logic          switch_on;
  logic          up_edge;
  logic          down_edge;

  // Each word is sampled twice; a word caught mid-change settles next sample
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q     <= '0;
      sync2_q     <= '0;
      trim_prev_q <= 2'h0;
    end
    else
    begin
      sync1_q     <= {analog_input_one, analog_input_two, pulse_input,
                      digital_input_terminal, source_switch, up_trim, down_trim};
      sync2_q     <= sync1_q;
      trim_prev_q <= sync2_q[1:0];
    end
  end

  assign an1       = sync2_q[52:37];
  assign an2       = sync2_q[36:21];
  assign pul       = sync2_q[20:5];
  assign group_sel = sync2_q[4:3];
  assign switch_on = sync2_q[2];
  assign up_edge   = sync2_q[1] & ~trim_prev_q[1];
  assign down_edge = sync2_q[0] & ~trim_prev_q[0];

  // ****************************************
  // Settings
  // ****************************************
  logic [31:0] ctrl_q;
  logic [7:0]  aux_pct_q;
  freq_t       offset_q;
  freq_t       preset_q;
  freq_t       maxf_q;
  freq_t       upper_q;
  freq_t       ul_offset_q;
  freq_t       lower_q;
  freq_t       comm_ul_q;
  logic [15:0] comm_src_q;
  logic [15:0] time_q [8];
  logic        wr;
  logic        time_hit;
  logic [2:0]  time_idx;
  freq_t       wfreq;

  assign wr       = psel & penable & pwrite;
  assign time_hit = paddr >= TIME_BASE_ADDR && paddr <= TIME_LAST_ADDR && paddr[1:0] == 2'h0;
  assign time_idx = 3'((paddr - TIME_BASE_ADDR) >> 2);
  assign wfreq    = pwdata[15:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q      <= CTRL_RST;
      aux_pct_q   <= AUX_PCT_RST;
      offset_q    <= 16'h0000;
      preset_q    <= PRESET_RST;
      maxf_q      <= MAXF_RST;
      upper_q     <= UPPER_RST;
      ul_offset_q <= 16'h0000;
      lower_q     <= 16'h0000;
      comm_ul_q   <= 16'h0000;
      comm_src_q  <= 16'h0000;
    end
    else if (wr)
    begin
      if (paddr == CTRL_ADDR)
        ctrl_q <= pwdata;
      else if (paddr == AUX_PCT_ADDR)
        aux_pct_q <= (pwdata[7:0] > AUX_PCT_MAX) ? AUX_PCT_MAX : pwdata[7:0];
      else if (paddr == OFFSET_ADDR)
        offset_q <= wfreq;
      else if (paddr == PRESET_ADDR)
        preset_q <= wfreq;
      else if (paddr == MAXF_ADDR)
        maxf_q <= fmin(fmax(wfreq, MAXF_MIN), FREQ_CAP);
      else if (paddr == UPPER_ADDR)
        upper_q <= wfreq;
      else if (paddr == UL_OFFSET_ADDR)
        ul_offset_q <= wfreq;
      else if (paddr == LOWER_ADDR)
        lower_q <= wfreq;
      else if (paddr == COMM_UL_ADDR)
        comm_ul_q <= wfreq;
      else if (paddr == COMM_SRC_ADDR)
        comm_src_q <= pwdata[15:0];
    end
  end

  // Stored values never change with the unit; only their weight does
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      time_q <= '{default: 16'h0000};
    else if (wr && time_hit)
      time_q[time_idx] <= pwdata[15:0];
  end

  logic [2:0] combo;
  logic [1:0] relation;
  logic [2:0] ul_src;
  logic [1:0] below_mode;
  logic [1:0] ref_sel;
  src_t       a_src;
  src_t       b_src;
  logic       run;

  assign combo      = ctrl_q[COMBO_LSB +: 3];
  assign relation   = ctrl_q[REL_LSB +: 2];
  assign ul_src     = ctrl_q[ULSRC_LSB +: 3];
  assign below_mode = ctrl_q[BELOW_LSB +: 2];
  assign ref_sel    = ctrl_q[REFSEL_LSB +: 2];
  assign a_src      = src_t'(ctrl_q[ASRC_LSB +: 3]);
  assign b_src      = src_t'(ctrl_q[BSRC_LSB +: 3]);
  assign run        = ctrl_q[RUN_BIT];

  // ****************************************
  // Limits
  // ****************************************
  freq_t upper_eff;
  freq_t lower_eff;
  freq_t upper_final;

  assign upper_eff = fmin(fmax(upper_q, lower_q), maxf_q);
  assign lower_eff = fmin(lower_q, upper_eff);

  always_comb
  begin
    case (ul_src)
      3'h1:    upper_final = sat_add(scale(upper_eff, an1), ul_offset_q);
      3'h2:    upper_final = sat_add(scale(upper_eff, an2), ul_offset_q);
      3'h4:    upper_final = sat_add(scale(maxf_q, pul), ul_offset_q);
      3'h5:    upper_final = comm_ul_q;
      default: upper_final = upper_eff;
    endcase
    upper_final = fmin(upper_final, maxf_q);
  end

  // ****************************************
  // Digital setting with up/down trim
  // ****************************************
  freq_t digital_q;
  freq_t out_freq;
  freq_t set_freq_q;
  logic  run_q;
  logic  digital_mode;
  freq_t trim_base;

  assign digital_mode = a_src == SRC_DIGITAL;
  assign trim_base    = ctrl_q[TRIM_BASE] ? set_freq_q : out_freq;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      digital_q <= PRESET_RST;
      run_q     <= 1'b0;
    end
    else
    begin
      run_q <= run;
      if (wr && paddr == PRESET_ADDR)
        digital_q <= fmin(wfreq, maxf_q);
      else if (run_q && !run && !ctrl_q[TRIM_MEM])
        digital_q <= fmin(preset_q, maxf_q);
      else if (digital_mode && up_edge && !down_edge)
        digital_q <= fmin(sat_add(trim_base, TRIM_STEP), maxf_q);
      else if (digital_mode && down_edge && !up_edge)
        digital_q <= (trim_base > TRIM_STEP) ? trim_base - TRIM_STEP : 16'h0000;
      else
        digital_q <= fmin(digital_q, maxf_q);
    end
  end

  // ****************************************
  // Main and auxiliary sources
  // ****************************************
  function automatic logic [15:0] src_pct(input src_t s);
    case (s)
      SRC_AN1:   return an1;
      SRC_AN2:   return an2;
      SRC_PULSE: return pul;
      SRC_COMM:  return comm_src_q;
      default:   return 16'h0000;
    endcase
  endfunction

  freq_t a_freq;
  freq_t b_range;
  freq_t b_freq;
  freq_t combined;
  freq_t chosen;
  logic  superpose;

  assign superpose = combo == 3'h1 || combo == 3'h3 || combo == 3'h4;

  // Inside the process, so the source words that the function reads wake it
  always_comb
  begin
    a_freq  = digital_mode ? digital_q : scale(maxf_q, src_pct(a_src));
    b_range = maxf_q;
    if (superpose)
    begin
      b_range = ctrl_q[AUX_REF] ? a_freq : maxf_q;
      // Saturates: 150 % of a high range would not fit the word
      b_range = scale(b_range, 16'(aux_pct_q) * AUX_PCT_DIV);
    end
    b_freq = (b_src == SRC_DIGITAL) ? fmin(digital_q, b_range)
                                    : scale(b_range, src_pct(b_src));
    case (relation)
      2'h0:    combined = sat_add(a_freq, b_freq);
      2'h1:    combined = (a_freq > b_freq) ? a_freq - b_freq : 16'h0000;
      2'h2:    combined = fmax(a_freq, b_freq);
      default: combined = fmin(a_freq, b_freq);
    endcase
    combined = sat_add(combined, offset_q);
    case (combo)
      3'h1:    chosen = combined;
      3'h2:    chosen = switch_on ? b_freq : a_freq;
      3'h3:    chosen = switch_on ? combined : a_freq;
      3'h4:    chosen = switch_on ? combined : b_freq;
      default: chosen = a_freq;
    endcase
  end

  // ****************************************
  // Clamp and ramp request
  // ****************************************
  logic  below_stop;
  freq_t clamped;

  always_comb
  begin
    below_stop = 1'b0;
    clamped    = fmin(chosen, upper_final);
    if (clamped < lower_eff)
    begin
      case (below_mode)
        2'h1:    below_stop = 1'b1;
        2'h2:    clamped = 16'h0000;
        default: clamped = lower_eff;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      set_freq_q <= 16'h0000;
    else
      set_freq_q <= clamped;
  end

  function automatic logic [39:0] span(input logic [15:0] t, input logic [1:0] u);
    logic [39:0] c;
    case (time_unit_t'(u))
      UNIT_1S:   c = 40'(CENTISECOND_CYCLES) * 40'h00_0000_0064;
      UNIT_10MS: c = 40'(CENTISECOND_CYCLES);
      default:   c = 40'(CENTISECOND_CYCLES) * 40'h00_0000_000A;
    endcase
    return 40'(t) * c;
  endfunction

  ramp_req_t req;

  always_comb
  begin
    req.target = (run && !below_stop) ? set_freq_q : 16'h0000;
    case (ref_sel)
      2'h1:    req.reference = set_freq_q;
      2'h2:    req.reference = REF_100HZ;
      default: req.reference = maxf_q;
    endcase
    req.accel_cycles = span(time_q[{group_sel, 1'b0}], ctrl_q[UNIT_LSB +: 2]);
    req.decel_cycles = span(time_q[{group_sel, 1'b1}], ctrl_q[UNIT_LSB +: 2]);
  end

  ramp_stepper u_ramp (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (req),
    .freq_q  (out_freq)
  );

  assign output_frequency = out_freq;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_active <= 1'b0;
    else
      run_active <= out_freq != 16'h0000 || (run && !below_stop);
  end

  // ****************************************
  // APB read path
  // ****************************************
  logic [31:0] rdata_d;
  logic        bad_d;
  logic        bad_q;
  logic [31:0] status;

  assign status = {28'h000_0000, out_freq == upper_final, below_stop, run_active, run};

  always_comb
  begin
    bad_d = 1'b0;
    if (paddr == CTRL_ADDR)
      rdata_d = {ctrl_q[31:30], RESOLUTION_CODE, ctrl_q[27:0]};
    else if (paddr == AUX_PCT_ADDR)
      rdata_d = {24'h00_0000, aux_pct_q};
    else if (paddr == OFFSET_ADDR)
      rdata_d = {16'h0000, offset_q};
    else if (paddr == PRESET_ADDR)
      rdata_d = {16'h0000, preset_q};
    else if (paddr == MAXF_ADDR)
      rdata_d = {16'h0000, maxf_q};
    else if (paddr == UPPER_ADDR)
      rdata_d = {16'h0000, upper_q};
    else if (paddr == UL_OFFSET_ADDR)
      rdata_d = {16'h0000, ul_offset_q};
    else if (paddr == LOWER_ADDR)
      rdata_d = {16'h0000, lower_q};
    else if (paddr == COMM_UL_ADDR)
      rdata_d = {16'h0000, comm_ul_q};
    else if (paddr == COMM_SRC_ADDR)
      rdata_d = {16'h0000, comm_src_q};
    else if (paddr == OUTF_ADDR)
      rdata_d = {16'h0000, out_freq};
    else if (paddr == SETF_ADDR)
      rdata_d = {16'h0000, set_freq_q};
    else if (paddr == UL_FINAL_ADDR)
      rdata_d = {16'h0000, upper_final};
    else if (paddr == STATUS_ADDR)
      rdata_d = status;
    else if (time_hit)
      rdata_d = {16'h0000, time_q[time_idx]};
    else
    begin
      rdata_d = 32'h0000_0000;
      bad_d   = 1'b1;
    end
  end

  // Captured in setup so the access phase answers from flip-flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      bad_q  <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata <= pwrite ? 32'h0000_0000 : rdata_d;
      bad_q  <= bad_d;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & bad_q;

endmodule // freq_reference_ramp

// ### verification/freq_ramp_checker.sv
/* Port checker of the frequency ramp block.
   Assumes APB and all outputs on pclk. */
`timescale 1ns/100ps
module freq_ramp_checker
  import freq_ramp_pkg::*;
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic [7:0]           paddr,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire freq_ramp_pkg::freq_t output_frequency,
  input wire logic                 run_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  wire logic rdx = acc && !pwrite;
  // ****************************************
  // Checks
  // ****************************************
  a_freq_cap: assert property (output_frequency <= FREQ_CAP)
    else $error("output above cap");
  a_res_code: assert property (rdx && paddr == CTRL_ADDR |->
    prdata[29:28] == RESOLUTION_CODE) else $error("bad resolution code");
  a_maxf_range: assert property (rdx && paddr == MAXF_ADDR |->
    prdata[15:0] inside {[MAXF_MIN:FREQ_CAP]}) else $error("maxf out of range");
  a_err_phase: assert property (pslverr |-> acc) else $error("slverr outside access");
  a_ready_high: assert property (acc |-> pready) else $error("pready low");
  a_unmapped_err: assert property (acc && paddr == 8'h38 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
  // Data is loaded in setup, so it shows the previous cycle's output
  a_outf_read: assert property (rdx && paddr == OUTF_ADDR |->
    prdata[15:0] == $past(output_frequency)) else $error("output read differs");
  a_reset_idle: assert property ($rose(presetn) |-> output_frequency == 16'h0000 && !run_active)
    else $error("not idle after reset");
  c_read_out: cover property (rdx && paddr == OUTF_ADDR);
  c_slverr: cover property (pslverr);
  c_run: cover property ($rose(run_active));
endmodule // freq_ramp_checker

// ### verification/pin_partner.sv
/* Keypad, terminal and sensor model on the far side of the pins.
   Assumes the bench calls press and set_group between its checks. */
`timescale 1ns/100ps
module pin_partner (
  input  wire logic        pclk,
  output logic      [15:0] analog_one,
  output logic      [15:0] analog_two,
  output logic      [15:0] pulse,
  output logic      [1:0]  terminal,
  output logic             switch_on,
  output logic             up_pin,
  output logic             down_pin
);
  // ****************************************
  // Pins
  // ****************************************
  initial
  begin
    analog_one = 16'h1D4C;
    analog_two = 16'h1388;
    pulse = 16'h09C4;
    terminal = 2'h0;
    switch_on = 1'b0;
    up_pin = 1'b0;
    down_pin = 1'b0;
  end
  // Extra cycles cover the two-stage pin synchroniser
  task automatic set_group(input logic [1:0] g);
    @(posedge pclk);
    terminal <= g;
    repeat (3) @(posedge pclk);
  endtask
  task automatic set_levels(input logic s, input logic [15:0] a2);
    @(posedge pclk);
    switch_on <= s;
    analog_two <= a2;
    repeat (3) @(posedge pclk);
  endtask
  // Pin low again for several cycles so each press is seen once
  task automatic press(input logic up);
    @(posedge pclk);
    up_pin <= up;
    down_pin <= !up;
    repeat (3) @(posedge pclk);
    up_pin <= 1'b0;
    down_pin <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
endmodule // pin_partner

// ### verification/freq_reference_ramp_tb_top.sv
/* Bench of the frequency reference ramp block: table rows, then reset,
   bus errors, ramp timing and trimming. Assumes checker and pin model. */
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module freq_reference_ramp_tb_top;
  import freq_ramp_pkg::*;
  typedef struct packed {logic [31:0] c; freq_t p, l, o, e;} row_t;
  typedef struct packed {logic [1:0] u, s; freq_t cyc;} ramp_t;
  localparam logic [31:0] B = 32'h0140_8000;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, err, sw, up_p, dn_p, run;
  logic [15:0] an1, an2, pls;
  logic [1:0]  term;
  freq_t       outf;
  int          errors = 0, compares = 0, n;
  row_t rows [19] = '{
    '{B, 16'h07D0, 16'h0000, 16'h0064, 16'h07D0},
    '{B | 32'h01, 16'h07D0, 16'h0000, 16'h0000, 16'h1388},
    '{B | 32'h11, 16'h07D0, 16'h0000, 16'h0000, 16'h0000},
    '{B | 32'h21, 16'h07D0, 16'h0000, 16'h0000, 16'h0BB8},
    '{B | 32'h31, 16'h07D0, 16'h0000, 16'h0064, 16'h0834},
    '{B | 32'h41, 16'h07D0, 16'h0000, 16'h0000, 16'h0BB8},
    '{B | 32'h200, 16'h157C, 16'h0000, 16'h0000, 16'h11C6},
    '{B | 32'h400, 16'h157C, 16'h0000, 16'h0000, 16'h0C1C},
    '{B | 32'h600, 16'h157C, 16'h0000, 16'h0000, 16'h157C},
    '{B | 32'h800, 16'h157C, 16'h0000, 16'h0000, 16'h06A4},
    '{B | 32'hA00, 16'h157C, 16'h0000, 16'h0000, 16'h0DAC},
    '{B | 32'h42, 16'h07D0, 16'h0000, 16'h0000, 16'h0BB8},
    '{B | 32'h43, 16'h07D0, 16'h0000, 16'h0064, 16'h0C1C},
    '{B | 32'h04, 16'h07D0, 16'h0000, 16'h0000, 16'h1388},
    '{B | 32'h0004_0000, 16'h07D0, 16'h0000, 16'h0000, 16'h1194},
    '{B, 16'h1770, 16'h0000, 16'h0000, 16'h16A8},
    '{B, 16'h03E8, 16'h09C4, 16'h0000, 16'h09C4},
    '{B | 32'h1000, 16'h03E8, 16'h09C4, 16'h0000, 16'h0000},
    '{B | 32'h2000, 16'h03E8, 16'h09C4, 16'h0000, 16'h0000}};
  ramp_t ramps [5] = '{'{2'h2, 2'h0, 16'h0064}, '{2'h1, 2'h0, 16'h03E8},
    '{2'h0, 2'h0, 16'h2710}, '{2'h2, 2'h2, 16'h003C}, '{2'h2, 2'h1, 16'h2710}};

  freq_reference_ramp #(.CENTISECOND_CYCLES(100)) u_dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_input_one(an1),
    .analog_input_two(an2), .pulse_input(pls), .digital_input_terminal(term),
    .source_switch(sw), .up_trim(up_p), .down_trim(dn_p), .output_frequency(outf),
    .run_active(run));
  pin_partner u_pins (.pclk(pclk), .analog_one(an1), .analog_two(an2), .pulse(pls),
    .terminal(term), .switch_on(sw), .up_pin(up_p), .down_pin(dn_p));

  always #50 pclk = ~pclk;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Polls the output, since settling depends on synchroniser depth
  task automatic settle(input freq_t e);
    n = 0;
    do
    begin
      apb(1'b0, OUTF_ADDR, 32'h0);
      n++;
    end
    while (rd[15:0] !== e && n < 40);
  endtask
  task automatic setup();
    apb(1'b1, MAXF_ADDR, 32'h0000_1770);
    apb(1'b1, UPPER_ADDR, 32'h0000_16A8);
    apb(1'b1, UL_OFFSET_ADDR, 32'h0000_00C8);
    apb(1'b1, COMM_UL_ADDR, 32'h0000_0DAC);
  endtask
  task automatic stop_start(input logic [31:0] c);
    apb(1'b1, CTRL_ADDR, c);
    apb(1'b1, CTRL_ADDR, c | 32'h0100_0000);
  endtask
  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #10_000_000;
    errors++;
    final_report();
  end

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    u_pins.set_levels(1'b1, 16'h1388);
    setup();
    foreach (rows[i])
    begin
      apb(1'b1, PRESET_ADDR, {16'h0000, rows[i].p});
      apb(1'b1, LOWER_ADDR, {16'h0000, rows[i].l});
      apb(1'b1, OFFSET_ADDR, {16'h0000, rows[i].o});
      apb(1'b1, CTRL_ADDR, rows[i].c);
      settle(rows[i].e);
      `CHK("output", rows[i].e, rd[15:0])
    end
    apb(1'b1, CTRL_ADDR, B | 32'h1000);
    settle(16'h0000);
    `CHK("active", 1'b0, run)
    u_pins.set_levels(1'b0, 16'h1F40);
    apb(1'b1, CTRL_ADDR, B | 32'h04);
    settle(16'h12C0);
    `CHK("aux only", 16'h12C0, rd[15:0])
    @(posedge pclk) presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_ADDR, 32'h0);
    `CHK("ctrl", 32'h2000_4000, rd)
    apb(1'b0, PRESET_ADDR, 32'h0);
    `CHK("preset", 32'h0000_1388, rd)
    apb(1'b1, MAXF_ADDR, 32'h0000_FFFF);
    apb(1'b0, MAXF_ADDR, 32'h0);
    `CHK("maxf", 32'h0000_EA60, rd)
    apb(1'b0, 8'h38, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    setup();
    apb(1'b1, 8'h50, 32'h0000_0064);
    foreach (ramps[i])
    begin
      u_pins.set_group(2'h0);
      apb(1'b1, CTRL_ADDR, {8'h01, 6'h00, ramps[i].s, ramps[i].u, 14'h0000});
      apb(1'b1, PRESET_ADDR, 32'h0);
      settle(16'h0000);
      u_pins.set_group(2'h2);
      apb(1'b1, PRESET_ADDR, 32'h0000_003C);
      n = 0;
      while (outf !== 16'h003C && n < 20000)
      begin
        @(posedge pclk);
        n++;
      end
      n = n - int'(ramps[i].cyc);
      `CHK("ramp", 1'b1, n >= -2 && n <= 8)
    end
    u_pins.set_group(2'h0);
    apb(1'b1, CTRL_ADDR, 32'h0100_8080);
    apb(1'b1, PRESET_ADDR, 32'h0000_07D0);
    repeat (3) u_pins.press(1'b1);
    settle(16'h07D3);
    `CHK("trim", 16'h07D3, rd[15:0])
    stop_start(32'h0000_8080);
    settle(16'h07D0);
    `CHK("no memory", 16'h07D0, rd[15:0])
    apb(1'b1, CTRL_ADDR, 32'h0100_8180);
    u_pins.press(1'b0);
    stop_start(32'h0000_8180);
    settle(16'h07CF);
    `CHK("memory", 16'h07CF, rd[15:0])
    final_report();
  end
endmodule // freq_reference_ramp_tb_top

bind freq_reference_ramp freq_ramp_checker u_chk (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .output_frequency(output_frequency),
  .run_active(run_active));
